// ==== bench/cfd_reader_model.sv ====
// Purpose: Far-side reader: consumes FIFO messages and serves the DMA request
// Assumes: Acks are one-cycle pulses launched just after a rising edge
// Notes:   Gap between acks makes the reader prompt or slow
`timescale 1ns/1ns
module cfd_reader_model (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_start,
  input  wire logic       i_fifo,
  input  wire logic [3:0] i_count,
  input  wire logic [1:0] i_gap,
  input  wire logic       i_dma_en,
  input  wire logic       i_dma_req,
  output logic      [1:0] o_fifo_ack,
  output logic            o_dma_ack,
  output logic            o_busy
);
  logic [3:0] left_q;
  logic [1:0] wait_q;
  logic [1:0] gap_q;
  logic       sel_q;
  logic [1:0] dma_cnt_q;

  assign o_busy = (left_q != 4'h0);

  // ****************************************************************
  // Message reads, one ack per message taken
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      left_q     <= 4'h0;
      wait_q     <= 2'h0;
      gap_q      <= 2'h0;
      sel_q      <= 1'b0;
      o_fifo_ack <= 2'h0;
    end else if (i_start) begin
      left_q <= i_count;
      gap_q  <= i_gap;
      sel_q  <= i_fifo;
      wait_q <= 2'h0;
    end else if (o_fifo_ack != 2'h0) begin
      o_fifo_ack <= 2'h0;
      wait_q     <= gap_q;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (left_q != 4'h0) begin
      o_fifo_ack <= sel_q ? 2'h2 : 2'h1;
      left_q     <= left_q - 4'h1;
    end
  end

  // ****************************************************************
  // DMA service: keeps acking while the request stands
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dma_cnt_q <= 2'h0;
      o_dma_ack <= 1'b0;
    end else if (o_dma_ack || !(i_dma_en && i_dma_req)) begin
      dma_cnt_q <= 2'h0;
      o_dma_ack <= 1'b0;
    end else if (dma_cnt_q == 2'h3) begin
      o_dma_ack <= 1'b1;
    end else begin
      dma_cnt_q <= dma_cnt_q + 2'h1;
    end
  end
endmodule // cfd_reader_model

// ==== bench/cfd_rx_dbg_tb_top.sv ====
// Purpose: Self-checking bench for the receive top pointer and debug state logic
// Assumes: Reader model drives FIFO and DMA acks
// Notes:   Read data compared against a queue of expected words
`timescale 1ns/1ns
`include "cfd_regs.svh"
module cfd_rx_dbg_tb_top;
  localparam logic [15:0] STRIDE = 16'h0010;
  logic        clk, arst_n, wr, rd, dbg_msg, bus_off, start, sel, dma_en, dma_ack;
  logic        dma_req, irq, busy, rd_pend;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rnd;
  logic [1:0]  fifo_ack, dbg_state, gap;
  logic [3:0]  cnt;
  logic [15:0] top0, top1, base0, base1;
  logic [31:0] exp_q[$];
  int          fail_count, checks_done, i;

  cfd_rx_dbg #(.ELEM_BYTES(STRIDE), .ERRATUM(1'b1)) dut_u (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_FIFO_ACK(fifo_ack), .I_DBG_MSG(dbg_msg),
    .I_BUS_OFF(bus_off), .I_DMA_ACK(dma_ack), .O_TOP_ADDR0(top0), .O_TOP_ADDR1(top1),
    .O_DBG_STATE(dbg_state), .O_DMA_REQ(dma_req), .O_IRQ(irq));

  cfd_reader_model model_u (
    .i_clk(clk), .i_arst_n(arst_n), .i_start(start), .i_fifo(sel), .i_count(cnt),
    .i_gap(gap), .i_dma_en(dma_en), .i_dma_req(dma_req), .o_fifo_ack(fifo_ack),
    .o_dma_ack(dma_ack), .o_busy(busy));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic complete_run;
    $display("Mismatches %0d, checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    exp_q.push_back(e);
    @(posedge clk) rd <= 1'b0;
  endtask

  task automatic send_msg(input logic [1:0] e);
    @(posedge clk) dbg_msg <= 1'b1;
    @(posedge clk) dbg_msg <= 1'b0;
    #1 chk({30'h0, dbg_state}, {30'h0, e});
    chk({31'h0, dma_req}, {31'h0, e == 2'h3});
  endtask

  task automatic read_fifo(input logic f, input logic [3:0] n);
    @(posedge clk) begin start <= 1'b1; sel <= f; cnt <= n; gap <= 2'($urandom % 4); end
    @(posedge clk) start <= 1'b0;
    #1;
    for (i = 0; i < 100 && busy; i++) @(posedge clk);
    if (i == 100) begin
      fail_count++;
      complete_run();
    end
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend) chk(rdata, exp_q.pop_front());
    rd_pend <= rd;
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {arst_n, wr, rd, dbg_msg, bus_off, start, sel, dma_en} = 8'h0;
    {addr, wdata, cnt, gap} = 46'h0;
    fail_count = 0;
    checks_done = 0;
    rnd = $urandom(9);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(`CFD_OFF_CTRL, 32'h1);
    rd_reg(`CFD_OFF_FIFO0_CFG, 32'h0);
    rd_reg(`CFD_OFF_FIFO1_STAT, 32'h0);
    rd_reg(`CFD_OFF_INT_MASK, 32'h0);
    rd_reg(8'h20, 32'h0);
    base0 = rnd[15:0] & 16'hFFF0;
    wr_reg(`CFD_OFF_FIFO0_CFG, {9'h0, 7'h02, base0});
    rd_reg(`CFD_OFF_FIFO0_CFG, {9'h0, 7'h02, base0});
    wr_reg(`CFD_OFF_INT_MASK, 32'hF);
    read_fifo(1'b0, 4'h3);
    chk({16'h0, top0}, {16'h0, 16'(base0 + STRIDE)});
    chk({31'h0, irq}, 32'h1);
    rd_reg(`CFD_OFF_FIFO0_TOP, {16'h0, 16'(base0 + STRIDE)});
    rd_reg(`CFD_OFF_INT_STAT, 32'h4);
    rd_reg(`CFD_OFF_INT_STAT, 32'h0);
    base1 = 16'($urandom) & 16'hFFF0;
    wr_reg(`CFD_OFF_FIFO1_CFG, {9'h0, 7'h01, base1});
    read_fifo(1'b1, 4'h2);
    chk({16'h0, top1}, {16'h0, 16'(base1 + 2 * STRIDE)});
    rd_reg(`CFD_OFF_INT_STAT, 32'h0);
    wr_reg(`CFD_OFF_INT_MASK, 32'h2);
    wr_reg(`CFD_OFF_CTRL, 32'h4);
    send_msg(2'h1);
    send_msg(2'h2);
    send_msg(2'h3);
    rd_reg(`CFD_OFF_FIFO1_STAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`CFD_OFF_CTRL, 32'h5);
    dma_en <= 1'b1;
    repeat (12) @(posedge clk);
    #1 chk({30'h0, dbg_state, dma_req}, 32'h7);
    wr_reg(`CFD_OFF_CTRL, 32'h7);
    rd_reg(`CFD_OFF_FIFO1_STAT, 32'h3);
    wr_reg(`CFD_OFF_CTRL, 32'h4);
    for (i = 0; i < 20 && dbg_state !== 2'h0; i++) @(posedge clk);
    if (i == 20) begin
      fail_count++;
      complete_run();
    end
    #1 chk({31'h0, dma_req}, 32'h0);
    dma_en <= 1'b0;
    rd_reg(`CFD_OFF_INT_STAT, 32'h3);
    send_msg(2'h1);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk) bus_off <= 1'b1;
    send_msg(2'h1);
    @(posedge clk) bus_off <= 1'b0;
    send_msg(2'h0);
    send_msg(2'h1);
    send_msg(2'h2);
    wr_reg(`CFD_OFF_CTRL, 32'h5);
    send_msg(2'h2);
    wr_reg(`CFD_OFF_CTRL, 32'h4);
    send_msg(2'h0);
    send_msg(2'h1);
    @(posedge clk) bus_off <= 1'b1;
    send_msg(2'h1);
    @(posedge clk) arst_n <= 1'b0;
    @(posedge clk) begin arst_n <= 1'b1; bus_off <= 1'b0; end
    #1 chk({30'h0, dbg_state}, 32'h0);
    rd_reg(`CFD_OFF_CTRL, 32'h1);
    wr_reg(`CFD_OFF_CTRL, 32'h4);
    send_msg(2'h1);
    wr_reg(`CFD_OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk({30'h0, dbg_state}, 32'h0);
    send_msg(2'h0);
    rd_reg(`CFD_OFF_FIFO1_STAT, 32'h0);
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule // cfd_rx_dbg_tb_top

// ==== logic/cfd_pkg.sv ====
// Purpose: Types shared by the receive debug block and its top-pointer unit
// Assumes: Nothing beyond the register header
// Notes:   Types only; constants live in cfd_regs.svh
package cfd_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    DBG_IDLE,
    DBG_GOT1,
    DBG_GOT2,
    DBG_READY
  } cfd_dbg_e;

  typedef struct packed {
    logic [6:0]  depth;
    logic [15:0] base;
  } cfd_fifo_cfg_s;

endpackage

// ==== logic/cfd_regs.svh ====
// Purpose: Register offsets, field positions and reset values of the receive debug block
// Assumes: Byte offsets on an 8-bit register address, 32-bit data
// Notes:   Definitions only
`ifndef CFD_REGS_SVH
`define CFD_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define CFD_OFF_CTRL        8'h00
`define CFD_OFF_FIFO0_CFG   8'h04
`define CFD_OFF_FIFO1_CFG   8'h08
`define CFD_OFF_FIFO0_TOP   8'h0C
`define CFD_OFF_FIFO1_TOP   8'h10
`define CFD_OFF_FIFO1_STAT  8'h14
`define CFD_OFF_INT_STAT    8'h18
`define CFD_OFF_INT_MASK    8'h1C

// ****************************************************************
// Fields
// ****************************************************************
`define CFD_CTRL_HOLD       0
`define CFD_CTRL_CCE        1
`define CFD_CTRL_DBGEN      2
`define CFD_FCFG_BASE_LSB   0
`define CFD_FCFG_BASE_MSB   15
`define CFD_FCFG_DEPTH_LSB  16
`define CFD_FCFG_DEPTH_MSB  22
`define CFD_STAT_DMS_LSB    0
`define CFD_STAT_DMS_MSB    1
`define CFD_INT_DBG_MSG     0
`define CFD_INT_DMA_REQ     1
`define CFD_INT_WRAP0       2
`define CFD_INT_WRAP1       3
`define CFD_INT_BITS        4

// ****************************************************************
// Reset values
// ****************************************************************
`define CFD_CTRL_RST        3'h1
`define CFD_FCFG_RST        23'h000000
`define CFD_INT_MASK_RST    4'h0

`endif

// ==== logic/cfd_rx_dbg.sv ====
// Purpose: Receive FIFO top pointers and debug message state machine with register port
// Assumes: Reader and message path are synchronous to I_CLK
// Notes:   Plain register port, read data one cycle after the read strobe
//
// Functional notes
// - Hardware computes top pointer message address
// - Top pointer wraps to start after size
// - Size one: pointer fails to wrap
// - Hold or bus-off freezes debug state
// - Change-enable write leaves debug state alone
// - Debug disabled keeps state machine idle
// - Debug state reported in second FIFO status
// - State 0b11 holds DMA request asserted
// - Stopped 0b01/0b10 cleared by reset or message
`timescale 1ns/1ns
`include "cfd_regs.svh"
module cfd_rx_dbg #(
  parameter logic [15:0] ELEM_BYTES = 16'h0010,
  parameter logic        ERRATUM    = 1'b1
) (
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  input  wire logic [1:0]  I_FIFO_ACK,
  input  wire logic        I_DBG_MSG,
  input  wire logic        I_BUS_OFF,
  input  wire logic        I_DMA_ACK,
  output logic      [15:0] O_TOP_ADDR0,
  output logic      [15:0] O_TOP_ADDR1,
  output logic      [1:0]  O_DBG_STATE,
  output logic             O_DMA_REQ,
  output logic             O_IRQ
);

  logic                   hold_q;
  logic                   cce_q;
  logic                   dbg_en_q;
  cfd_pkg::cfd_fifo_cfg_s cfg0_q;
  cfd_pkg::cfd_fifo_cfg_s cfg1_q;
  cfd_pkg::cfd_dbg_e      st_q;
  cfd_pkg::cfd_dbg_e      st_d;
  logic                   stopped_q;
  logic                   stopped_d;
  logic [3:0]             sts_q;
  logic [3:0]             mask_q;
  logic [3:0]             mask_d;
  logic [3:0]             events;
  logic [1:0]             wrap;
  logic                   wr_ctrl;
  logic                   wr_cfg0;
  logic                   wr_cfg1;
  logic                   rd_sts;
  logic                   frozen;

  function automatic logic [1:0] st_code(input cfd_pkg::cfd_dbg_e s);
    case (s)
      cfd_pkg::DBG_IDLE:  st_code = 2'h0;
      cfd_pkg::DBG_GOT1:  st_code = 2'h1;
      cfd_pkg::DBG_GOT2:  st_code = 2'h2;
      cfd_pkg::DBG_READY: st_code = 2'h3;
      default:            st_code = 2'h0;
    endcase
  endfunction

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign wr_ctrl = I_WR && (I_ADDR == `CFD_OFF_CTRL);
  assign wr_cfg0 = I_WR && (I_ADDR == `CFD_OFF_FIFO0_CFG);
  assign wr_cfg1 = I_WR && (I_ADDR == `CFD_OFF_FIFO1_CFG);
  assign rd_sts  = I_RD && (I_ADDR == `CFD_OFF_INT_STAT);

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      {dbg_en_q, cce_q, hold_q} <= `CFD_CTRL_RST;
    end else if (wr_ctrl) begin
      hold_q   <= I_WDATA[`CFD_CTRL_HOLD];
      // Change enable is stored only; the debug machine never looks at it
      cce_q    <= I_WDATA[`CFD_CTRL_CCE];
      dbg_en_q <= I_WDATA[`CFD_CTRL_DBGEN];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg0_q <= `CFD_FCFG_RST;
      cfg1_q <= `CFD_FCFG_RST;
    end else begin
      if (wr_cfg0) begin
        cfg0_q <= I_WDATA[`CFD_FCFG_DEPTH_MSB:`CFD_FCFG_BASE_LSB];
      end
      if (wr_cfg1) begin
        cfg1_q <= I_WDATA[`CFD_FCFG_DEPTH_MSB:`CFD_FCFG_BASE_LSB];
      end
    end
  end

  // Next mask feeds the interrupt, so a mask write acts without a lag
  assign mask_d = (I_WR && (I_ADDR == `CFD_OFF_INT_MASK)) ? I_WDATA[`CFD_INT_BITS-1:0]
                                                           : mask_q;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mask_q <= `CFD_INT_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ****************************************************************
  // Top pointers
  // ****************************************************************
  // Size one stays broken in compatible mode; the reader must use a
  // depth of two or more there, or fetch straight from message RAM
  cfd_top_ptr #(.ELEM_BYTES(ELEM_BYTES)) u_ptr0 (
    .i_clk     (I_CLK),
    .i_arst_n  (I_ARST_N),
    .i_cfg     (cfg0_q),
    .i_clr     (wr_cfg0),
    .i_ack     (I_FIFO_ACK[0]),
    .i_erratum (ERRATUM),
    .o_addr    (O_TOP_ADDR0),
    .o_wrap    (wrap[0])
  );

  cfd_top_ptr #(.ELEM_BYTES(ELEM_BYTES)) u_ptr1 (
    .i_clk     (I_CLK),
    .i_arst_n  (I_ARST_N),
    .i_cfg     (cfg1_q),
    .i_clr     (wr_cfg1),
    .i_ack     (I_FIFO_ACK[1]),
    .i_erratum (ERRATUM),
    .o_addr    (O_TOP_ADDR1),
    .o_wrap    (wrap[1])
  );

  // ****************************************************************
  // Debug message state machine
  // ****************************************************************
  assign frozen = hold_q || I_BUS_OFF;

  always_comb begin
    st_d      = st_q;
    stopped_d = stopped_q;
    if (!dbg_en_q) begin
      st_d      = cfd_pkg::DBG_IDLE;
      stopped_d = 1'b0;
    end else if (frozen) begin
      // Not sent back to idle; a DMA request in flight stays up
      st_d = st_q;
      if ((st_q == cfd_pkg::DBG_GOT1) || (st_q == cfd_pkg::DBG_GOT2)) begin
        stopped_d = 1'b1;
      end
    end else if (stopped_q && I_DBG_MSG) begin
      st_d      = cfd_pkg::DBG_IDLE;
      stopped_d = 1'b0;
    end else begin
      case (st_q)
        cfd_pkg::DBG_IDLE: begin
          if (I_DBG_MSG) begin
            st_d = cfd_pkg::DBG_GOT1;
          end
        end
        cfd_pkg::DBG_GOT1: begin
          if (I_DBG_MSG) begin
            st_d = cfd_pkg::DBG_GOT2;
          end
        end
        cfd_pkg::DBG_GOT2: begin
          if (I_DBG_MSG) begin
            st_d = cfd_pkg::DBG_READY;
          end
        end
        cfd_pkg::DBG_READY: begin
          if (I_DMA_ACK) begin
            st_d = cfd_pkg::DBG_IDLE;
          end
        end
        default: begin
          st_d = cfd_pkg::DBG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q      <= cfd_pkg::DBG_IDLE;
      stopped_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      stopped_q <= stopped_d;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_DBG_STATE <= 2'h0;
      O_DMA_REQ   <= 1'b0;
    end else begin
      O_DBG_STATE <= st_code(st_d);
      O_DMA_REQ   <= (st_d == cfd_pkg::DBG_READY);
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign events = {wrap[1], wrap[0],
                   (st_d == cfd_pkg::DBG_READY) && (st_q != cfd_pkg::DBG_READY),
                   I_DBG_MSG && dbg_en_q};

  // New event beats a clearing read in the same cycle
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sts_q <= 4'h0;
    end else begin
      sts_q <= (rd_sts ? 4'h0 : sts_q) | events;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(((rd_sts ? 4'h0 : sts_q) | events) & mask_d);
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        `CFD_OFF_CTRL:       O_RDATA <= {29'h0, dbg_en_q, cce_q, hold_q};
        `CFD_OFF_FIFO0_CFG:  O_RDATA <= {9'h0, cfg0_q};
        `CFD_OFF_FIFO1_CFG:  O_RDATA <= {9'h0, cfg1_q};
        `CFD_OFF_FIFO0_TOP:  O_RDATA <= {16'h0, O_TOP_ADDR0};
        `CFD_OFF_FIFO1_TOP:  O_RDATA <= {16'h0, O_TOP_ADDR1};
        `CFD_OFF_FIFO1_STAT: O_RDATA <= {30'h0, st_code(st_q)};
        `CFD_OFF_INT_STAT:   O_RDATA <= {28'h0, sts_q};
        `CFD_OFF_INT_MASK:   O_RDATA <= {28'h0, mask_q};
        default:             O_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_hold_freeze: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (dbg_en_q && $past(dbg_en_q) && $past(frozen)) |-> (st_q == $past(st_q)))
    else $error("debug state moved while frozen");

  a_cce_no_effect: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (wr_ctrl && I_WDATA[`CFD_CTRL_DBGEN] && dbg_en_q && !I_DBG_MSG && !I_DMA_ACK)
      |=> (st_q == $past(st_q)))
    else $error("control write changed debug state");

  a_disabled_idle: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !dbg_en_q |=> (st_q == cfd_pkg::DBG_IDLE && O_DBG_STATE == 2'h0))
    else $error("debug machine left idle while disabled");

  a_status_field: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == `CFD_OFF_FIFO1_STAT) |=> (O_RDATA[1:0] == $past(O_DBG_STATE)))
    else $error("status field does not show debug state");

  a_dma_level: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (O_DBG_STATE == 2'h3) |-> O_DMA_REQ)
    else $error("DMA request low in state three");

  a_dma_frozen: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (O_DMA_REQ && dbg_en_q && frozen) |=> O_DMA_REQ [*1])
    else $error("DMA request dropped while frozen");

  a_stopped_idle: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (stopped_q && I_DBG_MSG && dbg_en_q && !frozen)
      |=> (st_q == cfd_pkg::DBG_IDLE && O_DBG_STATE == 2'h0))
    else $error("stopped machine not returned to idle");

  a_count_step: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (st_q == cfd_pkg::DBG_IDLE && dbg_en_q && !frozen && !stopped_q && I_DBG_MSG)
      |=> (O_DBG_STATE == 2'h1))
    else $error("first debug message not counted");

  a_dma_exit: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_DMA_REQ |-> (O_DBG_STATE == 2'h3))
    else $error("DMA request without state three");

  a_irq_level: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_IRQ == |(sts_q & mask_q))
    else $error("interrupt does not follow masked status");

endmodule // cfd_rx_dbg

// ==== logic/cfd_top_ptr.sv ====
// Purpose: Receive FIFO top pointer: message RAM address of the next message to read
// Assumes: i_ack is a one-cycle pulse per message consumed by the reader
// Notes:   A depth of zero disables the FIFO and freezes the pointer
`timescale 1ns/1ns
module cfd_top_ptr #(
  parameter logic [15:0] ELEM_BYTES = 16'h0010
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire cfd_pkg::cfd_fifo_cfg_s i_cfg,
  input  wire logic                  i_clr,
  input  wire logic                  i_ack,
  input  wire logic                  i_erratum,
  output logic [15:0]                o_addr,
  output logic                       o_wrap
);

  logic [6:0] idx_q;
  logic [6:0] idx_d;
  logic       wrap_d;

  // ****************************************************************
  // Index
  // ****************************************************************
  always_comb begin
    idx_d  = idx_q;
    wrap_d = 1'b0;
    if (i_clr) begin
      idx_d = 7'h00;
    end else if (i_ack && (i_cfg.depth != 7'h00)) begin
      // Single-element FIFO keeps counting in compatible mode
      if (i_erratum && (i_cfg.depth == 7'h01)) begin
        idx_d = idx_q + 7'h01;
      end else if (idx_q >= (i_cfg.depth - 7'h01)) begin
        idx_d  = 7'h00;
        wrap_d = 1'b1;
      end else begin
        idx_d = idx_q + 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_q <= 7'h00;
    end else begin
      idx_q <= idx_d;
    end
  end

  // ****************************************************************
  // Address
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_addr <= 16'h0000;
      o_wrap <= 1'b0;
    end else begin
      o_addr <= i_cfg.base + 16'(idx_q * ELEM_BYTES);
      o_wrap <= wrap_d;
    end
  end

  a_wrap_start: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ack && !i_clr && i_cfg.depth > 7'h01 && idx_q == i_cfg.depth - 7'h01)
      |=> (idx_q == 7'h00))
    else $error("top pointer did not return to start");

  a_single_slip: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ack && !i_clr && i_erratum && i_cfg.depth == 7'h01)
      |=> (idx_q == $past(idx_q) + 7'h01))
    else $error("single element pointer did not advance");

  a_addr_calc: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    1'b1 |=> (o_addr == $past(i_cfg.base) + 16'($past(idx_q) * ELEM_BYTES)))
    else $error("top address wrong");

endmodule // cfd_top_ptr
